// file: common/pbl_defs.svh
// Constants for the pushbutton on/off latch: timing figures, cycle counts,
// register offsets and field positions.
// Assumes a 100 MHz core clock; cycle counts derive from that rate.
`ifndef PBL_DEFS_SVH
`define PBL_DEFS_SVH

`define PBL_CLK_MHZ 100
`define PBL_CYC_PER_US `PBL_CLK_MHZ
`define PBL_CYC_PER_MS (`PBL_CLK_MHZ * 1000)
`define PBL_CYC_PER_S (`PBL_CLK_MHZ * 1000000)

`define PBL_GLITCH_US 600
`define PBL_GLITCH_CYC (`PBL_GLITCH_US * `PBL_CYC_PER_US)
`define PBL_DB_SHORT_MS 50
`define PBL_DB_SHORT_CYC (`PBL_DB_SHORT_MS * `PBL_CYC_PER_MS)
`define PBL_DB_LONG_S 2
`define PBL_DB_LONG_CYC (`PBL_DB_LONG_S * `PBL_CYC_PER_S)
`define PBL_SO_SHORT_S 8
`define PBL_SO_SHORT_CYC (`PBL_SO_SHORT_S * `PBL_CYC_PER_S)
`define PBL_SO_LONG_S 16
`define PBL_SO_LONG_CYC (`PBL_SO_LONG_S * `PBL_CYC_PER_S)
`define PBL_PULSE_SHORT_MS 32
`define PBL_PULSE_SHORT_CYC (`PBL_PULSE_SHORT_MS * `PBL_CYC_PER_MS)
`define PBL_PULSE_LONG_MS 128
`define PBL_PULSE_LONG_CYC (`PBL_PULSE_LONG_MS * `PBL_CYC_PER_MS)
`define PBL_LOCK_MULT 2

`define PBL_AW 4
`define PBL_DW 8
`define PBL_REG_STATUS 4'h0
`define PBL_REG_MASK 4'h4
`define PBL_REG_STATE 4'h8
`define PBL_MASK_RST 8'h00

`define PBL_EV_DEB 0
`define PBL_EV_SHUT 1
`define PBL_EV_CLR 2
`define PBL_EV_W 3

`define PBL_ST_LATCH 0
`define PBL_ST_FSM 1
`define PBL_ST_IRQ 3
`define PBL_ST_PIN 4
`define PBL_ST_LOCK 5

`endif

// file: common/pbl_pkg.sv
// Types for the pushbutton on/off latch.
// Constants live in pbl_defs.svh; this holds the state encoding only.
package pbl_pkg;

   // Gray along idle -> press -> held -> done
   typedef enum logic [1:0] {
      PBL_IDLE = 2'b00,
      PBL_PRESS = 2'b01,
      PBL_HELD = 2'b11,
      PBL_DONE = 2'b10
   } pbl_state_t;

endpackage : pbl_pkg

// file: hw/pbl_latch.sv
// Pushbutton on/off latch: debounce, power latch, one-shot interrupt pulse,
// clear input with lockout, and a small register port with sticky events.
// Assumes a 100 MHz clk, pins arriving asynchronously, and an outside
// pad that resolves the open-drain pulse pin from its enable.
`timescale 1ns/10ps
`include "pbl_defs.svh"

module pbl_latch #(
   parameter bit DB_SEL = 1'b0,
   parameter bit SO_SEL = 1'b0,
   parameter bit SHUT_OFF = 1'b1,
   parameter logic [31:0] GLITCH_CYC = `PBL_GLITCH_CYC,
   parameter logic [31:0] DB_CYC = DB_SEL ? `PBL_DB_LONG_CYC : `PBL_DB_SHORT_CYC,
   parameter logic [31:0] SO_CYC = SO_SEL ? `PBL_SO_LONG_CYC : `PBL_SO_SHORT_CYC,
   parameter logic [31:0] PULSE_SHORT_CYC = `PBL_PULSE_SHORT_CYC,
   parameter logic [31:0] PULSE_LONG_CYC = `PBL_PULSE_LONG_CYC,
   parameter logic [31:0] LOCK_CYC = `PBL_LOCK_MULT * `PBL_PULSE_SHORT_CYC
) (
   input wire logic clk,
   input wire logic rstn,
   input wire logic pushbutton_n,
   input wire logic clear_n,
   input wire logic irq_pulse_n_i,
   output logic irq_pulse_n_o,
   output logic irq_pulse_n_oe,
   output logic power_latch_out,
   output logic sys_irq,
   input wire logic [`PBL_AW-1:0] reg_addr,
   input wire logic [`PBL_DW-1:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [`PBL_DW-1:0] reg_rdata
);

   // Reset release through two flops
   logic rst_meta_r;
   logic rst_n_r;

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         rst_meta_r <= 1'b0;
         rst_n_r <= 1'b0;
      end else begin
         rst_meta_r <= 1'b1;
         rst_n_r <= rst_meta_r;
      end
   end

   // Pin synchronisers; idle pins read high
   logic [2:0] pin_s;
   logic pb_s;
   logic clr_s;
   logic irq_pin_s;

   pbl_sync #(
      .W(3),
      .RST_VAL(3'h7)
   ) u_sync (
      .clk(clk),
      .rst_n(rst_n_r),
      .d({irq_pulse_n_i, clear_n, pushbutton_n}),
      .q(pin_s)
   );

   assign pb_s = pin_s[0];
   assign clr_s = pin_s[1];
   assign irq_pin_s = pin_s[2];

   // State and counters
   pbl_pkg::pbl_state_t st_r;
   pbl_pkg::pbl_state_t st_nxt;
   logic [31:0] hi_cnt_r;
   logic [31:0] hi_cnt_nxt;
   logic [31:0] cnt_r;
   logic [31:0] cnt_nxt;
   logic [31:0] pul_cnt_r;
   logic [31:0] pul_cnt_nxt;
   logic [31:0] lock_cnt_r;
   logic [31:0] lock_cnt_nxt;
   logic latch_r;
   logic latch_nxt;
   logic irq_oe_r;

   wire rel_hit = pb_s && (hi_cnt_r >= GLITCH_CYC - 32'h1);
   assign hi_cnt_nxt = !pb_s ? 32'h0 :
                       rel_hit ? hi_cnt_r : hi_cnt_r + 32'h1;

   wire deb_hit = (st_r == pbl_pkg::PBL_PRESS) && !rel_hit &&
                  (cnt_r >= DB_CYC - 32'h1);
   wire so_hit = (st_r == pbl_pkg::PBL_HELD) && !rel_hit &&
                 (cnt_r >= SO_CYC - 32'h1);

   // clear honoured only when latched and unlocked
   wire clr_ok = !clr_s && latch_r && (lock_cnt_r == 32'h0);

   // Closure sequencer
   always_comb begin
      st_nxt = st_r;
      unique case (st_r)
         pbl_pkg::PBL_IDLE: begin
            if (!pb_s) begin
               st_nxt = pbl_pkg::PBL_PRESS;
            end
         end
         pbl_pkg::PBL_PRESS: begin
            if (rel_hit) begin
               st_nxt = pbl_pkg::PBL_IDLE;
            end else if (deb_hit) begin
               st_nxt = pbl_pkg::PBL_HELD;
            end
         end
         pbl_pkg::PBL_HELD: begin
            if (rel_hit) begin
               st_nxt = pbl_pkg::PBL_IDLE;
            end else if (so_hit) begin
               st_nxt = pbl_pkg::PBL_DONE;
            end
         end
         pbl_pkg::PBL_DONE: begin
            if (rel_hit) begin
               st_nxt = pbl_pkg::PBL_IDLE;
            end
         end
      endcase
   end

   // closure length counted in clk cycles
   // Saturates in done so a stuck button cannot wrap
   assign cnt_nxt = (st_r == pbl_pkg::PBL_IDLE) ? 32'h0 :
                    (st_r == pbl_pkg::PBL_DONE) ? cnt_r : cnt_r + 32'h1;

   // long pulse at end of shutdown period
   // only these two loads, so no retrigger
   assign pul_cnt_nxt = so_hit ? PULSE_LONG_CYC :
                        deb_hit ? PULSE_SHORT_CYC :
                        (pul_cnt_r != 32'h0) ? pul_cnt_r - 32'h1 : 32'h0;

   // shut-off option clears on long closure
   assign latch_nxt = deb_hit ? 1'b1 :
                      ((so_hit && SHUT_OFF) || clr_ok) ? 1'b0 : latch_r;

   // lockout starts at each rising latch
   assign lock_cnt_nxt = (latch_nxt && !latch_r) ? LOCK_CYC :
                         (lock_cnt_r != 32'h0) ? lock_cnt_r - 32'h1 : 32'h0;

   always_ff @(posedge clk or negedge rst_n_r) begin
      if (!rst_n_r) begin
         st_r <= pbl_pkg::PBL_IDLE;
         hi_cnt_r <= 32'h0;
         cnt_r <= 32'h0;
         pul_cnt_r <= 32'h0;
         lock_cnt_r <= 32'h0;
         latch_r <= 1'b0;
         irq_oe_r <= 1'b0;
      end else begin
         st_r <= st_nxt;
         hi_cnt_r <= hi_cnt_nxt;
         cnt_r <= cnt_nxt;
         pul_cnt_r <= pul_cnt_nxt;
         lock_cnt_r <= lock_cnt_nxt;
         latch_r <= latch_nxt;
         irq_oe_r <= (pul_cnt_nxt != 32'h0);
      end
   end

   assign irq_pulse_n_o = 1'b0;
   assign irq_pulse_n_oe = irq_oe_r;
   // driven both ways from a flop
   assign power_latch_out = latch_r;

   // Register port
   logic [`PBL_EV_W-1:0] sts_r;
   logic [`PBL_EV_W-1:0] sts_nxt;
   logic [`PBL_DW-1:0] mask_r;
   logic [`PBL_DW-1:0] rdata_r;
   logic irq_r;

   wire sel_sts = (reg_addr == `PBL_REG_STATUS);
   wire sel_mask = (reg_addr == `PBL_REG_MASK);
   wire sel_state = (reg_addr == `PBL_REG_STATE);

   wire [`PBL_EV_W-1:0] ev;
   assign ev[`PBL_EV_DEB] = deb_hit;
   assign ev[`PBL_EV_SHUT] = so_hit;
   assign ev[`PBL_EV_CLR] = clr_ok;

   // Set beats a same-cycle write-one clear
   wire [`PBL_EV_W-1:0] w1c = (reg_wr && sel_sts) ?
                              reg_wdata[`PBL_EV_W-1:0] : '0;
   assign sts_nxt = (sts_r & ~w1c) | ev;

   wire [`PBL_DW-1:0] sts_word = {{(`PBL_DW-`PBL_EV_W){1'b0}}, sts_r};

   wire [`PBL_DW-1:0] state_word;
   assign state_word[`PBL_ST_LATCH] = latch_r;
   assign state_word[`PBL_ST_FSM+1:`PBL_ST_FSM] = st_r;
   assign state_word[`PBL_ST_IRQ] = irq_oe_r;
   assign state_word[`PBL_ST_PIN] = irq_pin_s;
   assign state_word[`PBL_ST_LOCK] = (lock_cnt_r != 32'h0);
   assign state_word[`PBL_DW-1:`PBL_ST_LOCK+1] = '0;

   // Unmapped reads return zero
   wire [`PBL_DW-1:0] rd_mux = sel_sts ? sts_word :
                               sel_mask ? mask_r :
                               sel_state ? state_word : '0;

   wire irq_nxt = |(sts_word & mask_r);

   always_ff @(posedge clk or negedge rst_n_r) begin
      if (!rst_n_r) begin
         sts_r <= '0;
         mask_r <= `PBL_MASK_RST;
         rdata_r <= '0;
         irq_r <= 1'b0;
      end else begin
         sts_r <= sts_nxt;
         if (reg_wr && sel_mask) begin
            mask_r <= reg_wdata;
         end
         rdata_r <= reg_rd ? rd_mux : '0;
         irq_r <= irq_nxt;
      end
   end

   assign reg_rdata = rdata_r;
   assign sys_irq = irq_r;

   // Checks
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!rst_n_r);

   latch_set_a: assert property (
      deb_hit |=> power_latch_out && (st_r == pbl_pkg::PBL_HELD))
      else $error("latch not set after debounce");

   short_pulse_a: assert property (
      deb_hit && !so_hit |=> irq_pulse_n_oe ##1
      (irq_pulse_n_oe && pul_cnt_r == PULSE_SHORT_CYC - 32'h1))
      else $error("short pulse wrong length");

   long_pulse_a: assert property (
      so_hit |=> (pul_cnt_r == PULSE_LONG_CYC) && irq_pulse_n_oe
      ##1 (pul_cnt_r == PULSE_LONG_CYC - 32'h1))
      else $error("extended pulse not started");

   shut_off_a: assert property (
      so_hit && SHUT_OFF && !deb_hit |=> !power_latch_out)
      else $error("latch kept on long closure");

   keep_on_a: assert property (
      so_hit && !SHUT_OFF && latch_r && !clr_ok |=> power_latch_out)
      else $error("latch dropped on long closure");

   clear_off_a: assert property (
      !clr_s && latch_r && lock_cnt_r == 32'h0 && !deb_hit
      |=> !power_latch_out)
      else $error("clear did not turn latch off");

   clear_idle_a: assert property (
      !power_latch_out && !deb_hit |=> !power_latch_out)
      else $error("latch rose without debounce");

   od_pin_a: assert property (
      !irq_pulse_n_o && (irq_pulse_n_oe == (pul_cnt_r != 32'h0)))
      else $error("pulse pin drive mismatch");

   glitch_hold_a: assert property (
      st_r == pbl_pkg::PBL_PRESS && pb_s &&
      hi_cnt_r < GLITCH_CYC - 32'h1 |=> st_r != pbl_pkg::PBL_IDLE)
      else $error("short high broke debounce");

   clr_lock_a: assert property (
      $rose(power_latch_out) |-> lock_cnt_r == LOCK_CYC
      ##1 power_latch_out || $past(so_hit))
      else $error("clear lockout not loaded");

   no_retrig_a: assert property (
      st_r == pbl_pkg::PBL_DONE && pul_cnt_r == 32'h0 |=> !irq_pulse_n_oe)
      else $error("pulse retriggered while held");

   one_event_a: assert property (
      st_r == pbl_pkg::PBL_DONE && !pb_s |=> st_r == pbl_pkg::PBL_DONE)
      else $error("closure rearmed without release");

   sticky_set_a: assert property (
      deb_hit |=> sts_r[`PBL_EV_DEB] ##1 (sys_irq == mask_r[`PBL_EV_DEB]) ||
      sts_r[`PBL_EV_SHUT] || sts_r[`PBL_EV_CLR])
      else $error("debounce event not sticky");

   latch_timing_a: assert property (
      $rose(power_latch_out) |-> ($past(st_r) == pbl_pkg::PBL_PRESS) &&
      ($past(cnt_r) == DB_CYC - 32'h1))
      else $error("latch rose off the debounce count");

   pulse_end_a: assert property (
      irq_pulse_n_oe && pul_cnt_r == 32'h1 && !deb_hit && !so_hit |=> !irq_pulse_n_oe)
      else $error("pulse did not end on count");

   restart_a: assert property (
      st_r != pbl_pkg::PBL_IDLE && rel_hit |=> st_r == pbl_pkg::PBL_IDLE ##1 cnt_r == 32'h0)
      else $error("release did not restart timing");

   // Lockout must hide a low clear right after the rise
   clr_ignore_a: assert property (
      latch_r && lock_cnt_r != 32'h0 && !so_hit |=> power_latch_out)
      else $error("clear honoured during lockout");

   irq_level_a: assert property (
      1'b1 |=> sys_irq == $past(|(sts_r & mask_r[`PBL_EV_W-1:0])))
      else $error("interrupt level mismatch");

endmodule : pbl_latch

// file: hw/pbl_sync.sv
// Two-flop synchroniser, one stage pair per bit.
// Assumes inputs are asynchronous levels; reset value set per instance.
`timescale 1ns/10ps

module pbl_sync #(
   parameter int W = 1,
   parameter logic [W-1:0] RST_VAL = '0
) (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic [W-1:0] d,
   output logic [W-1:0] q
);

   genvar i;
   generate
      for (i = 0; i < W; i++) begin : g_bit
         logic meta_r;
         logic sync_r;
         always_ff @(posedge clk or negedge rst_n) begin
            if (!rst_n) begin
               meta_r <= RST_VAL[i];
               sync_r <= RST_VAL[i];
            end else begin
               meta_r <= d[i];
               sync_r <= meta_r;
            end
         end
         assign q[i] = sync_r;
      end
   endgenerate

endmodule : pbl_sync

// file: verif/pbl_button_model.sv
// Pushbutton switch with contact bounce, plus the pull-up pad of the pulse pin.
// Assumes the bench moves press and bounce by non-blocking assignment at a clock edge.
`timescale 1ns/10ps

module pbl_button_model (
   input wire logic clk,
   input wire logic press,
   input wire logic bounce,
   input wire logic irq_o,
   input wire logic irq_oe,
   output logic pushbutton_n,
   output logic irq_pad
);
   logic press_r = 1'b0;
   logic [3:0] bcnt_r = 4'h0;

   assign irq_pad = irq_oe ? irq_o : 1'b1;

   initial pushbutton_n = 1'b1;

   always @(posedge clk) begin
      press_r <= press;
      if (press && !press_r && bounce)
         bcnt_r <= 4'hC;
      else if (bcnt_r != 4'h0)
         bcnt_r <= bcnt_r - 4'h1;
      pushbutton_n <= !press || bcnt_r[2];
   end
endmodule : pbl_button_model

// file: verif/pbl_latch_bench.sv
// Self-checking bench for the pushbutton on/off latch with shortened counts.
// Assumes the design's own assertions run alongside; a second instance keeps on.
`timescale 1ns/10ps
`include "pbl_defs.svh"

module pbl_latch_bench;
   localparam logic [31:0] P_DB = 32'h14;
   localparam logic [31:0] P_PS = 32'h8;
   localparam logic [31:0] P_PL = 32'h1E;
   localparam logic [31:0] P_GL = 32'h6;
   localparam logic [31:0] P_SO = 32'hC8;
   localparam logic [31:0] P_LK = 32'h10;
   logic clk = 1'b0;
   logic rstn = 1'b0;
   logic press = 1'b0;
   logic bounce = 1'b0;
   logic clear_n = 1'b1;
   logic [3:0] reg_addr = 4'h0;
   logic [7:0] reg_wdata = 8'h00;
   logic reg_wr = 1'b0;
   logic reg_rd = 1'b0;
   logic pushbutton_n, irq_pad, irq_o, irq_oe, power_latch_out, sys_irq, keep_latch;
   logic [7:0] reg_rdata;
   logic [7:0] rd;
   int n_errors = 0;
   int cmp_count = 0;
   int n;

   always #5 clk = ~clk;

   pbl_button_model u_btn (.clk(clk), .press(press), .bounce(bounce), .irq_o(irq_o), .irq_oe(irq_oe),
      .pushbutton_n(pushbutton_n), .irq_pad(irq_pad));
   pbl_latch #(.SHUT_OFF(1'b1), .GLITCH_CYC(P_GL), .DB_CYC(P_DB), .SO_CYC(P_SO), .PULSE_SHORT_CYC(P_PS),
      .PULSE_LONG_CYC(P_PL), .LOCK_CYC(P_LK)) u_dut (.clk(clk), .rstn(rstn), .pushbutton_n(pushbutton_n),
      .clear_n(clear_n), .irq_pulse_n_i(irq_pad), .irq_pulse_n_o(irq_o), .irq_pulse_n_oe(irq_oe),
      .power_latch_out(power_latch_out), .sys_irq(sys_irq), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata));
   pbl_latch #(.SHUT_OFF(1'b0), .GLITCH_CYC(P_GL), .DB_CYC(P_DB), .SO_CYC(P_SO), .PULSE_SHORT_CYC(P_PS),
      .PULSE_LONG_CYC(P_PL), .LOCK_CYC(P_LK)) u_keep (.clk(clk), .rstn(rstn), .pushbutton_n(pushbutton_n),
      .clear_n(clear_n), .irq_pulse_n_i(irq_pad), .irq_pulse_n_o(), .irq_pulse_n_oe(),
      .power_latch_out(keep_latch), .sys_irq(), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata());

   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      cmp_count++;
      if (got !== exp) begin
         n_errors++;
         $display("ERROR %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk

   task automatic cyc(input int k);
      repeat (k) @(posedge clk);
      #1;
   endtask : cyc

   task automatic reg_write(input logic [3:0] a, input logic [7:0] d);
      @(posedge clk);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge clk);
      reg_wr <= 1'b0;
   endtask : reg_write

   // Read data stand only in the cycle after the strobe
   task automatic reg_read(input logic [3:0] a, output logic [7:0] d);
      @(posedge clk);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge clk);
      reg_rd <= 1'b0;
      #1;
      d = reg_rdata;
   endtask : reg_read

   task automatic wait_latch(input logic v, input int lim);
      n = 0;
      while (power_latch_out !== v && n < lim) begin
         cyc(1);
         n++;
      end
   endtask : wait_latch

   task automatic pulse_len(output int len);
      len = 0;
      while (irq_oe === 1'b1 && len < 200) begin
         len++;
         cyc(1);
      end
   endtask : pulse_len

   task automatic test_reset();
      chk(power_latch_out, 1'b0);
      chk(irq_oe, 1'b0);
      chk(irq_pad, 1'b1);
      reg_read(`PBL_REG_MASK, rd);
      chk(rd, `PBL_MASK_RST);
      reg_read(4'hC, rd);
      chk(rd, 8'h00);
      $display("test_reset done");
   endtask : test_reset

   task automatic test_debounce();
      @(posedge clk);
      press <= 1'b1;
      bounce <= 1'b1;
      cyc(10);
      @(posedge clk);
      press <= 1'b0;
      cyc(12);
      @(posedge clk);
      press <= 1'b1;
      cyc(16);
      chk(power_latch_out, 1'b0);
      wait_latch(1'b1, 20);
      chk(power_latch_out, 1'b1);
      chk(irq_pad, 1'b0);
      pulse_len(n);
      chk(8'(n), P_PS[7:0]);
      chk(irq_pad, 1'b1);
      @(posedge clk);
      press <= 1'b0;
      clear_n <= 1'b0;
      cyc(3);
      chk(power_latch_out, 1'b1);
      wait_latch(1'b0, 20);
      chk(power_latch_out, 1'b0);
      cyc(5);
      chk(power_latch_out, 1'b0);
      reg_read(`PBL_REG_STATUS, rd);
      chk(rd, 8'h05);
      reg_write(`PBL_REG_MASK, 8'h01);
      cyc(3);
      chk(sys_irq, 1'b1);
      reg_write(`PBL_REG_STATUS, 8'h05);
      cyc(3);
      chk(sys_irq, 1'b0);
      reg_read(`PBL_REG_STATUS, rd);
      chk(rd, 8'h00);
      @(posedge clk);
      clear_n <= 1'b1;
      $display("test_debounce done");
   endtask : test_debounce

   task automatic test_long();
      @(posedge clk);
      press <= 1'b1;
      bounce <= 1'b0;
      wait_latch(1'b1, 40);
      chk(keep_latch, 1'b1);
      pulse_len(n);
      chk(8'(n), P_PS[7:0]);
      // Drop the debounce event so a second one would show
      reg_write(`PBL_REG_STATUS, 8'h01);
      n = 0;
      while (irq_oe !== 1'b1 && n < 250) begin
         cyc(1);
         n++;
      end
      chk(8'(n > 150), 8'h01);
      pulse_len(n);
      chk(8'(n), P_PL[7:0]);
      chk(power_latch_out, 1'b0);
      chk(keep_latch, 1'b1);
      cyc(60);
      chk(irq_oe, 1'b0);
      reg_read(`PBL_REG_STATE, rd);
      chk(rd, 8'h14);
      @(posedge clk);
      press <= 1'b0;
      cyc(20);
      reg_read(`PBL_REG_STATUS, rd);
      chk(rd, 8'h02);
      $display("test_long done");
   endtask : test_long

   task automatic final_report();
      $display("Comparisons %0d, mismatches %0d", cmp_count, n_errors);
      if (n_errors == 0 && cmp_count > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask : final_report

   // Run needs about 440 cycles
   initial begin
      #50000;
      n_errors++;
      $display("ERROR %0t: watchdog expired", $time);
      final_report();
   end

   initial begin
      repeat (12) @(posedge clk);
      rstn <= 1'b1;
      cyc(5);
      test_reset();
      test_debounce();
      test_long();
      final_report();
   end
endmodule : pbl_latch_bench
